/* dsa_pkg.sv */
// Package of the data-space access unit: constants, modes and carriers.
// Assumes a 16-bit core on one clock with a one-cycle-latency memory.
package dsa_pkg;

    // Address map
    localparam logic [15:0] DSA_SFR_END     = 16'h0800;
    localparam logic [15:0] DSA_NEAR_END    = 16'h2000;
    localparam int          DSA_NEAR_BITS   = 13;
    localparam int          DSA_EDS_BIT     = 15;
    localparam int          DSA_PAGE_OFF    = 9;
    localparam int          DSA_REGION_LSB  = 5;
    localparam int          DSA_REGIONS     = 64;

    // Pointer steps
    localparam logic [15:0] DSA_STEP_BYTE   = 16'h0001;
    localparam logic [15:0] DSA_STEP_WORD   = 16'h0002;

    // Extra cycles of extended-space reads
    localparam logic [1:0]  DSA_EXTRA_EDS   = 2'h1;
    localparam logic [1:0]  DSA_EXTRA_RPT   = 2'h2;
    localparam logic [1:0]  DSA_EXTRA_NONE  = 2'h0;
    localparam logic [1:0]  DSA_RPT_SLOW    = 2'h2;

    // Byte-lane strobes
    localparam logic [1:0]  DSA_LANE_NONE   = 2'h0;
    localparam logic [1:0]  DSA_LANE_LO     = 2'h1;
    localparam logic [1:0]  DSA_LANE_HI     = 2'h2;
    localparam logic [1:0]  DSA_LANE_BOTH   = 2'h3;

    // Reset values
    localparam logic [15:0] DSA_RST_WORD    = 16'h0000;
    localparam logic [22:0] DSA_RST_WADDR   = 23'h000000;

    typedef enum logic [1:0] {
        DSA_MODE_IND  = 2'h0,   // through the source pointer
        DSA_MODE_NEAR = 2'h1,   // 13-bit direct field
        DSA_MODE_FULL = 2'h2    // 16-bit direct field of moves
    } dsa_mode_t;

    typedef enum logic [1:0] {
        DSA_IDLE  = 2'b00,
        DSA_ISSUE = 2'b01,
        DSA_CAP   = 2'b11,
        DSA_HOLD  = 2'b10
    } dsa_state_t;

    typedef enum logic [1:0] {
        DSA_SRC_MEM  = 2'h0,
        DSA_SRC_SFR  = 2'h1,
        DSA_SRC_ZERO = 2'h2
    } dsa_src_t;

    typedef struct packed {
        logic        write;
        logic        byte_op;
        dsa_mode_t   mode;
        logic        postinc;
        logic        repeat_op;
        logic [15:0] field;
        logic [15:0] ptr;
        logic [15:0] wdata;
        logic [15:0] wreg_old;
        logic [9:0]  read_page_select;
    } dsa_req_t;

    typedef struct packed {
        logic        en;
        logic [1:0]  we;
        logic [22:0] waddr;
        logic [15:0] wdata;
    } dsa_port_t;

    typedef struct packed {
        logic        done;
        logic        addr_err;
        logic [15:0] rdata;
        logic [15:0] wreg_new;
        logic [15:0] ptr_new;
    } dsa_rsp_t;

endpackage

/* dsa_unit.sv */
// Data-space access unit: byte/word access, alignment trap, SPECIAL_FUNCTION_REGISTER and extended reads.
// Assumes requests from core logic on clk and memory data one cycle after en.
`timescale 1ns/1ps

// Function
// - Byte read fetches word, address bit0 selects
// - Selected byte returned on low eight bits
// - Shared word decode, one write strobe per lane
// - Post-increment pointer by one or two
// - Odd word address raises address error trap
// - Misaligned read completes; misaligned write suppressed
// - Byte load keeps working register upper byte
// - Near region reached by 13-bit direct field
// - Move direct field of 16 bits reaches all
// - Low 2 Kbytes decoded as SPECIAL_FUNCTION_REGISTER space
// - Unimplemented SPECIAL_FUNCTION_REGISTER addresses read as zero
// - SFRs implemented per 32-byte region
// - Extended read address is page joined offset
// - Extended reads cost extra cycles, repeat rules
module dsa_unit #(
    parameter logic [dsa_pkg::DSA_REGIONS-1:0] SFR_REGION_MAP = '1
) (
    input  wire logic              clk,       // Core clock
    input  wire logic              rst_n,     // Async reset
    input  wire logic              ce,        // Clock enable
    input  wire logic              req_valid, // Request strobe
    input  wire dsa_pkg::dsa_req_t req,       // Request fields
    output logic                   req_ready, // Idle, request taken
    output dsa_pkg::dsa_port_t     mem,       // Data memory port
    input  wire logic [15:0]       mem_rdata, // Memory read word
    output dsa_pkg::dsa_port_t     special_function_register,       // SPECIAL_FUNCTION_REGISTER port
    input  wire logic [15:0]       sfr_rdata, // SPECIAL_FUNCTION_REGISTER read word
    output dsa_pkg::dsa_rsp_t      rsp        // Answer to core
);
    import dsa_pkg::*;

    // Whole state of the unit in one register; one request in flight at a time
    typedef struct packed {
        dsa_state_t  state;
        logic        ready;
        logic        write;
        logic        byte_op;
        logic        lane_hi;
        logic        misalign;
        dsa_src_t    src;
        logic [1:0]  extra;
        logic [1:0]  rpt_cnt;
        logic [15:0] word;
        logic [15:0] wreg_old;
        logic [15:0] ptr_new;
        dsa_port_t   mem;
        dsa_port_t   special_function_register;
        dsa_rsp_t    rsp;
    } dsa_regs_t;

    localparam dsa_port_t PORT_RST = '{
        en:    1'b0,
        we:    DSA_LANE_NONE,
        waddr: DSA_RST_WADDR,
        wdata: DSA_RST_WORD
    };

    localparam dsa_rsp_t RSP_RST = '{
        done:     1'b0,
        addr_err: 1'b0,
        rdata:    DSA_RST_WORD,
        wreg_new: DSA_RST_WORD,
        ptr_new:  DSA_RST_WORD
    };

    localparam dsa_regs_t REGS_RST = '{
        state:    DSA_IDLE,
        ready:    1'b1,
        write:    1'b0,
        byte_op:  1'b0,
        lane_hi:  1'b0,
        misalign: 1'b0,
        src:      DSA_SRC_MEM,
        extra:    DSA_EXTRA_NONE,
        rpt_cnt:  DSA_EXTRA_NONE,
        word:     DSA_RST_WORD,
        wreg_old: DSA_RST_WORD,
        ptr_new:  DSA_RST_WORD,
        mem:      PORT_RST,
        special_function_register:      PORT_RST,
        rsp:      RSP_RST
    };

    dsa_regs_t r;
    dsa_regs_t next_r;

    // Request decode, combinational
    logic [15:0] effective_address;
    logic        eds_read;
    logic        in_sfr;
    logic        region_ok;
    logic        odd_word;
    logic [1:0]  lanes;
    logic [22:0] word_addr;
    logic [1:0]  extra;
    logic [7:0]  sel_byte;
    logic [15:0] cap_word;

    always_comb begin
        unique case (req.mode)
            DSA_MODE_NEAR: effective_address =
                {3'h0, req.field[DSA_NEAR_BITS-1:0]};
            DSA_MODE_FULL: effective_address = req.field;
            default:       effective_address = req.ptr;
        endcase
    end

    // Window opens only for reads with page bit 9 clear
    assign eds_read = !req.write
                    && effective_address[DSA_EDS_BIT]
                    && !req.read_page_select[DSA_PAGE_OFF];

    assign in_sfr = !eds_read
                  && (effective_address < DSA_SFR_END);

    // Region index spans the whole 2-Kbyte register space
    localparam int REGION_MSB = DSA_REGION_LSB + $clog2(DSA_REGIONS) - 1;

    assign region_ok = SFR_REGION_MAP[
        effective_address[REGION_MSB:DSA_REGION_LSB]];

    assign odd_word = !req.byte_op && effective_address[0];

    always_comb begin
        if (req.byte_op) begin
            lanes = effective_address[0] ? DSA_LANE_HI
                                         : DSA_LANE_LO;
        end else if (odd_word) begin
            // Port still pulses en, so a trapped write keeps the usual timing
            lanes = DSA_LANE_NONE;
        end else begin
            lanes = DSA_LANE_BOTH;
        end
    end

    // Word address drops bit 0; both lanes share it
    always_comb begin
        if (eds_read) begin
            word_addr = {req.read_page_select[8:0],
                         effective_address[14:1]};
        end else begin
            word_addr = {8'h00, effective_address[15:1]};
        end
    end

    // Repeat loops pay double for their first two extended reads
    always_comb begin
        if (!eds_read) begin
            extra = DSA_EXTRA_NONE;
        end else if (!req.repeat_op) begin
            extra = DSA_EXTRA_EDS;
        end else if (r.rpt_cnt < DSA_RPT_SLOW) begin
            extra = DSA_EXTRA_RPT;
        end else begin
            extra = DSA_EXTRA_NONE;
        end
    end

    // Source follows the port that was strobed for this request
    always_comb begin
        unique case (r.src)
            DSA_SRC_SFR:  cap_word = sfr_rdata;
            DSA_SRC_ZERO: cap_word = DSA_RST_WORD;
            default:      cap_word = mem_rdata;
        endcase
    end

    // Word the answer is built from: fresh in the capture cycle, held after.
    // Writes settle on zero so no stale read data leaks into their answer.
    logic [15:0] settled_word;

    always_comb begin
        if (r.state == DSA_CAP) begin
            settled_word = r.write ? DSA_RST_WORD : cap_word;
        end else begin
            settled_word = r.word;
        end
    end

    // Byte reads take their lane from the address bit kept in lane_hi
    assign sel_byte = r.lane_hi ? settled_word[15:8] : settled_word[7:0];

    always_comb begin
        next_r = r;
        next_r.mem.en = 1'b0;
        next_r.mem.we = DSA_LANE_NONE;
        next_r.special_function_register.en = 1'b0;
        next_r.special_function_register.we = DSA_LANE_NONE;
        next_r.rsp.done = 1'b0;
        next_r.rsp.addr_err = 1'b0;
        unique case (r.state)
            DSA_IDLE: begin
                if (req_valid) begin
                    next_r.state    = DSA_ISSUE;
                    next_r.write    = req.write;
                    next_r.byte_op  = req.byte_op;
                    next_r.lane_hi  = effective_address[0];
                    next_r.misalign = odd_word;
                    next_r.extra    = extra;
                    next_r.wreg_old = req.wreg_old;
                    // Any other request ends the run, so a new run pays again
                    if (eds_read && req.repeat_op) begin
                        if (r.rpt_cnt < DSA_RPT_SLOW) begin
                            next_r.rpt_cnt = r.rpt_cnt + 2'h1;
                        end
                    end else begin
                        next_r.rpt_cnt = DSA_EXTRA_NONE;
                    end
                    if (req.mode == DSA_MODE_IND && req.postinc) begin
                        next_r.ptr_new = req.ptr + (req.byte_op
                            ? DSA_STEP_BYTE : DSA_STEP_WORD);
                    end else begin
                        next_r.ptr_new = req.ptr;
                    end
                    // Unimplemented regions see no strobe; reads answer zero
                    // Byte writes replicate data so either lane sees it
                    if (in_sfr) begin
                        next_r.src = region_ok ? DSA_SRC_SFR
                                               : DSA_SRC_ZERO;
                        next_r.special_function_register.en    = region_ok;
                        next_r.special_function_register.waddr = word_addr;
                        next_r.special_function_register.we    = (req.write && region_ok)
                                         ? lanes : DSA_LANE_NONE;
                        next_r.special_function_register.wdata = req.byte_op
                            ? {2{req.wdata[7:0]}} : req.wdata;
                    end else begin
                        next_r.src       = DSA_SRC_MEM;
                        next_r.mem.en    = 1'b1;
                        next_r.mem.waddr = word_addr;
                        next_r.mem.we    = req.write
                                         ? lanes : DSA_LANE_NONE;
                        next_r.mem.wdata = req.byte_op
                            ? {2{req.wdata[7:0]}} : req.wdata;
                    end
                end
            end
            DSA_ISSUE: begin
                // Memory answers one cycle after en
                next_r.state = DSA_CAP;
            end
            DSA_CAP: begin
                // Misaligned read still fetches the even word
                next_r.word = settled_word;
                if (r.extra == DSA_EXTRA_NONE) begin
                    next_r.state = DSA_IDLE;
                    next_r.rsp.done = 1'b1;
                    next_r.rsp.addr_err = r.misalign;
                end else begin
                    next_r.state = DSA_HOLD;
                end
            end
            DSA_HOLD: begin
                next_r.extra = r.extra - 2'h1;
                if (r.extra == DSA_EXTRA_EDS) begin
                    next_r.state = DSA_IDLE;
                    next_r.rsp.done = 1'b1;
                    next_r.rsp.addr_err = r.misalign;
                end
            end
        endcase
        // Reads form rdata and wreg_new from the captured word; ptr_new comes from the request
        if (next_r.rsp.done) begin
            next_r.rsp.ptr_new = r.ptr_new;
            if (r.write) begin
                next_r.rsp.rdata    = DSA_RST_WORD;
                next_r.rsp.wreg_new = r.wreg_old;
            end else if (r.byte_op) begin
                next_r.rsp.rdata    = {8'h00, sel_byte};
                next_r.rsp.wreg_new = {r.wreg_old[15:8],
                                       sel_byte};
            end else begin
                next_r.rsp.rdata    = next_r.word;
                next_r.rsp.wreg_new = next_r.word;
            end
        end
        // Registered ready, so a new request is taken in the done cycle
        next_r.ready = (next_r.state == DSA_IDLE);
    end

    // Low ce freezes every field, outputs and answer included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= REGS_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // All outputs come straight from the state register
    assign req_ready = r.ready;
    assign mem       = r.mem;
    assign special_function_register       = r.special_function_register;
    assign rsp       = r.rsp;

endmodule

/* dsa_mem_model.sv */
// Word memory model for the unit's memory and SPECIAL_FUNCTION_REGISTER ports.
// Assumes read data is sampled one cycle after en; unwritten words read a fixed pattern.
`timescale 1ns/1ps
module dsa_mem_model (
    input  wire dsa_pkg::dsa_port_t port,  // Port from the unit
    input  wire logic               clk,   // Core clock
    output logic [15:0]             rdata  // Read word
);
    import dsa_pkg::*;
    logic [15:0] words [logic [22:0]];
    logic [15:0] cur;
    initial rdata = 16'h0000;
    always @(posedge clk) begin
        cur = words.exists(port.waddr) ? words[port.waddr] : port.waddr[15:0] ^ 16'h5a5a;
        if (port.en) begin
            if (port.we[0]) cur[7:0] = port.wdata[7:0];
            if (port.we[1]) cur[15:8] = port.wdata[15:8];
            if (port.we != 2'h0) words[port.waddr] = cur;
            rdata <= cur;
        end else begin
            rdata <= ~rdata;  // Stale word is never held
        end
    end
endmodule

/* dsa_unit_sva.sv */
// Checker for the data-space access unit, bound to its ports.
// Assumes ce stays high while a request with a timed check is in flight.
`timescale 1ns/1ps
module dsa_unit_sva (
    input wire logic               clk,       // Core clock
    input wire logic               rst_n,     // Async reset
    input wire logic               ce,        // Clock enable
    input wire logic               req_valid, // Request strobe
    input wire dsa_pkg::dsa_req_t  req,       // Request fields
    input wire logic               req_ready, // Idle
    input wire dsa_pkg::dsa_port_t mem,       // Memory port
    input wire logic [15:0]        mem_rdata, // Memory word
    input wire dsa_pkg::dsa_port_t special_function_register,       // SPECIAL_FUNCTION_REGISTER port
    input wire logic [15:0]        sfr_rdata, // SPECIAL_FUNCTION_REGISTER word
    input wire dsa_pkg::dsa_rsp_t  rsp        // Answer
);
    import dsa_pkg::*;
    logic acc, far, odd, eds;
    assign acc = ce && req_valid && req_ready;
    assign far = req.mode == DSA_MODE_FULL && req.field >= DSA_SFR_END && !req.field[15];
    assign odd = acc && far && !req.byte_op && req.field[0];
    assign eds = acc && !req.write && req.mode == DSA_MODE_IND && req.ptr[15]
                 && !req.read_page_select[9];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    word_strobe_a: assert property (acc && far && req.write && !req.byte_op && !req.field[0]
        |=> mem.en && mem.we == DSA_LANE_BOTH) else $error("word write lanes wrong");
    byte_lane_a: assert property (acc && far && req.write && req.byte_op
        |=> mem.we == ($past(req.field[0]) ? DSA_LANE_HI : DSA_LANE_LO))
        else $error("byte write lane wrong");
    odd_write_a: assert property (odd && req.write
        |=> mem.en && mem.we == DSA_LANE_NONE) else $error("misaligned write stored");
    odd_trap_a: assert property (odd |-> ##3 rsp.done && rsp.addr_err)
        else $error("misaligned access not trapped");
    byte_read_a: assert property (acc && far && !req.write && req.byte_op
        |-> ##3 rsp.done && rsp.rdata[15:8] == 8'h00) else $error("byte read upper not 0");
    eds_time_a: assert property (eds && !req.repeat_op
        |=> !rsp.done [*3] ##1 rsp.done) else $error("extended read timing wrong");
    eds_addr_a: assert property (eds
        |=> mem.en && mem.waddr == {$past(req.read_page_select[8:0]), $past(req.ptr[14:1])})
        else $error("extended address wrong");
    ptr_step_a: assert property (acc && req.mode == DSA_MODE_IND && req.postinc && !req.ptr[15]
        |-> ##3 rsp.ptr_new == $past(req.ptr, 3)
            + ($past(req.byte_op, 3) ? DSA_STEP_BYTE : DSA_STEP_WORD))
        else $error("pointer step wrong");
    busy_hold_a: assert property (acc |=> !req_ready ##1 !req_ready)
        else $error("ready high during access");
endmodule
bind dsa_unit dsa_unit_sva dsa_unit_sva_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .mem(mem),
    .mem_rdata(mem_rdata), .special_function_register(special_function_register), .sfr_rdata(sfr_rdata), .rsp(rsp));

/* tb.sv */
// Self-checking bench of the data-space access unit with memory and SPECIAL_FUNCTION_REGISTER models.
// Assumes the last SPECIAL_FUNCTION_REGISTER region is left unimplemented by the parameter below.
`timescale 1ns/1ps
module tb;
    import dsa_pkg::*;
    logic        clk, rst_n, ce, req_valid, req_ready;
    dsa_req_t    req;
    dsa_port_t   mem, special_function_register;
    logic [15:0] mem_rdata, sfr_rdata;
    dsa_rsp_t    rsp;
    int          num_errors, checks, cycles, n;
    dsa_unit #(.SFR_REGION_MAP({1'b0, {63{1'b1}}})) dsa_unit_inst (.clk(clk), .rst_n(rst_n),
        .ce(ce), .req_valid(req_valid), .req(req), .req_ready(req_ready), .mem(mem),
        .mem_rdata(mem_rdata), .special_function_register(special_function_register), .sfr_rdata(sfr_rdata), .rsp(rsp));
    dsa_mem_model dsa_mem_model_inst (.port(mem), .clk(clk), .rdata(mem_rdata));
    dsa_mem_model sfr_model_inst (.port(special_function_register), .clk(clk), .rdata(sfr_rdata));
    task automatic test_done;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: took %0d cycles, expected %0d", $time, got, exp);
        end
    endtask
    // One whole request; returns at the done cycle with n cycles counted
    task automatic go(input logic w, b, input dsa_mode_t m, input logic [15:0] a, d,
                      input logic [9:0] pg, input logic rp);
        @(negedge clk);
        req = '{write:w, byte_op:b, mode:m, postinc:1'b1, repeat_op:rp, field:a, ptr:a,
                wdata:d, wreg_old:16'hab00, read_page_select:pg};
        req_valid = 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            req_valid = 1'b0;
            n++;
        end while (rsp.done !== 1'b1 && n < 20);
        if (rsp.done !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: no answer to request", $time);
        end
    endtask
    task automatic t_word;
        go(1, 0, DSA_MODE_FULL, 16'h2000, 16'h1234, 0, 0);
        go(0, 0, DSA_MODE_FULL, 16'h2000, 0, 0, 0);
        chk(rsp.rdata, 16'h1234);
        go(1, 0, DSA_MODE_FULL, 16'h1000, 16'h7777, 0, 0);
        go(0, 0, DSA_MODE_NEAR, 16'hf000, 0, 0, 0);
        chk(rsp.rdata, 16'h7777);
        go(1, 0, DSA_MODE_FULL, 16'hf000, 16'h3c3c, 10'h200, 0);
        go(0, 0, DSA_MODE_FULL, 16'hf000, 0, 10'h200, 0);
        chk(rsp.rdata, 16'h3c3c);
        $display("word test done");
    endtask
    task automatic t_byte;
        go(1, 1, DSA_MODE_FULL, 16'h2003, 16'h005a, 0, 0);
        go(0, 1, DSA_MODE_FULL, 16'h2003, 0, 0, 0);
        chk(rsp.rdata, 16'h005a);
        chk(rsp.wreg_new, 16'hab5a);
        go(0, 0, DSA_MODE_FULL, 16'h2002, 0, 0, 0);
        chk(rsp.rdata, {8'h5a, 8'h01 ^ 8'h5a});
        go(0, 1, DSA_MODE_IND, 16'h2002, 0, 0, 0);
        chk(rsp.rdata, 16'h005b);
        chk(rsp.ptr_new, 16'h2003);
        go(0, 0, DSA_MODE_IND, 16'h2004, 0, 0, 0);
        chk(rsp.ptr_new, 16'h2006);
        $display("byte test done");
    endtask
    task automatic t_align;
        go(1, 0, DSA_MODE_FULL, 16'h2005, 16'hffff, 0, 0);
        chk({15'h0, rsp.addr_err}, 16'h0001);
        go(0, 0, DSA_MODE_FULL, 16'h2005, 0, 0, 0);
        chk({15'h0, rsp.addr_err}, 16'h0001);
        chk(rsp.rdata, 16'h1002 ^ 16'h5a5a);
        $display("alignment test done");
    endtask
    task automatic t_sfr;
        go(1, 0, DSA_MODE_FULL, 16'h0100, 16'h4321, 0, 0);
        go(0, 0, DSA_MODE_FULL, 16'h0100, 0, 0, 0);
        chk(rsp.rdata, 16'h4321);
        go(1, 0, DSA_MODE_FULL, 16'h07e2, 16'h1111, 0, 0);
        go(0, 0, DSA_MODE_NEAR, 16'h07e2, 0, 0, 0);
        chk(rsp.rdata, 16'h0000);
        go(0, 0, DSA_MODE_NEAR, 16'h07de, 0, 0, 0);
        chk(rsp.rdata, 16'h03ef ^ 16'h5a5a);
        $display("sfr test done");
    endtask
    task automatic t_eds;
        go(0, 0, DSA_MODE_IND, 16'h8800, 0, 10'h002, 0);
        chkn(n, 4);
        chk(rsp.rdata, 16'h8400 ^ 16'h5a5a);
        go(0, 0, DSA_MODE_IND, 16'h8802, 0, 10'h002, 1);
        chkn(n, 5);
        go(0, 0, DSA_MODE_IND, 16'h8804, 0, 10'h002, 1);
        chkn(n, 5);
        go(0, 0, DSA_MODE_IND, 16'h8806, 0, 10'h002, 1);
        chkn(n, 3);
        chk(rsp.rdata, 16'h8403 ^ 16'h5a5a);
        $display("extended read test done");
    endtask
    task automatic t_ce;
        fork
            go(0, 0, DSA_MODE_FULL, 16'h2000, 0, 0, 0);
            begin
                repeat (2) @(negedge clk);
                ce = 1'b0;
                repeat (2) @(negedge clk);
                ce = 1'b1;
            end
        join
        chkn(n, 5);
        chk(rsp.rdata, 16'h1234);
        $display("clock enable test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        t_word();
        t_byte();
        t_align();
        t_sfr();
        t_eds();
        t_ce();
        test_done();
    end
endmodule
